/* dv/mcid_seq_model.sv */
`timescale 1ns/1ns
module mcid_seq_model (
    input wire logic hclk,
    output logic instr_valid,
    output logic [15:0] instr
);
    initial begin
        instr_valid = 1'b0;
        instr = 16'h0000;
    end

    // One word per edge; last=0 keeps the qualifier up for back-to-back
    task automatic issue(input logic [15:0] w, input logic last);
        @(posedge hclk);
        instr_valid <= 1'b1;
        instr <= w;
        if (last) begin
            @(posedge hclk);
            instr_valid <= 1'b0;
            // Idle bus shows the inverse, so a stale word is never reused
            instr <= ~w;
        end
    endtask
endmodule

/* dv/test_microcore_config_instr_decoder.sv */
`timescale 1ns/1ns
module test_microcore_config_instr_decoder;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, instr_valid;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, arith_mode;
    logic [2:0] hsize;
    logic [15:0] instr, alu_index_operand_reg;
    logic [9:0] spi_address_reg, spi_addr;
    logic [5:0] index_base, data_ram_base;
    logic [3:0] conv_enable;
    logic base_source_sel, spi_source_sel, hs24_fbk_battery, hs24_auto_diag;
    logic arith_signed, arith_saturate, overflow_flag_en;
    logic instr_done, instr_denied;
    int miscompares = 0;
    int samples_checked = 0;

    mcid_decoder uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .instr_valid(instr_valid), .instr(instr),
        .alu_index_operand_reg(alu_index_operand_reg),
        .spi_address_reg(spi_address_reg),
        .base_source_sel(base_source_sel), .index_base(index_base),
        .data_ram_base(data_ram_base), .spi_source_sel(spi_source_sel),
        .spi_addr(spi_addr), .hs24_fbk_battery(hs24_fbk_battery),
        .hs24_auto_diag(hs24_auto_diag), .conv_enable(conv_enable),
        .arith_mode(arith_mode), .arith_signed(arith_signed),
        .arith_saturate(arith_saturate),
        .overflow_flag_en(overflow_flag_en),
        .instr_done(instr_done), .instr_denied(instr_denied)
    );

    mcid_seq_model seq (
        .hclk(hclk), .instr_valid(instr_valid), .instr(instr)
    );

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic [31:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Settings land on the taking edge; look just after it
    task automatic run(input logic [15:0] w);
        seq.issue(w, 1'b1);
        #1;
    endtask

    task automatic t_reset;
        logic [31:0] rd;
        chk(32'({base_source_sel, spi_source_sel}), 32'h0);
        chk(32'({hs24_fbk_battery, conv_enable}), 32'h0);
        chk(32'({hs24_auto_diag, index_base}), 32'h0);
        chk(32'(arith_mode), 32'h2);
        ahb(32'h0620, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
    endtask

    task automatic t_arith;
        for (int m = 0; m < 4; m++) begin
            run(mcid_pkg::STAL_PAT | 16'(m));
            chk(32'(arith_mode), 32'(m));
            chk(32'({arith_signed, arith_saturate}), 32'({~m[1], m[0]}));
            chk(32'({overflow_flag_en, instr_done}), 32'h3);
        end
        // Back-to-back words: the later one must win
        seq.issue(mcid_pkg::STAL_PAT | 16'h1, 1'b0);
        run(mcid_pkg::STAL_PAT | 16'h2);
        chk(32'({instr_done, arith_mode}), 32'h6);
        run(16'h3660);
        chk(32'({instr_done, arith_mode}), 32'h2);
    endtask

    task automatic t_base;
        run(mcid_pkg::STAB_PAT | 16'h3f);
        chk(32'(index_base), 32'h3f);
        run(mcid_pkg::SLAB_PAT | 16'h1);
        chk(32'({base_source_sel, data_ram_base}), 32'h55);
        run(mcid_pkg::SLAB_PAT);
        chk(32'({base_source_sel, data_ram_base}), 32'h3f);
    endtask

    task automatic t_spi;
        run(mcid_pkg::SLSA_PAT | 16'h1);
        chk(32'({spi_source_sel, spi_addr}), 32'h415);
        run(mcid_pkg::SLSA_PAT);
        chk(32'({spi_source_sel, spi_addr}), 32'h2a5);
    endtask

    task automatic t_fbk;
        logic [31:0] rd;
        logic [1:0] codes [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
        logic diag [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        run(mcid_pkg::SLFBK_PAT | 16'h7);
        chk(32'({instr_denied, hs24_fbk_battery, hs24_auto_diag}), 32'h4);
        // Rights given to another core, then only half of our own
        ahb(32'h0614, 1'b1, 32'h000a, rd);
        run(mcid_pkg::SLFBK_PAT | 16'h7);
        chk(32'({instr_denied, hs24_fbk_battery, hs24_auto_diag}), 32'h4);
        ahb(32'h0610, 1'b1, 32'h0002, rd);
        run(mcid_pkg::SLFBK_PAT | 16'h7);
        chk(32'({instr_denied, hs24_fbk_battery, hs24_auto_diag}), 32'h4);
        ahb(32'h0610, 1'b1, 32'h000a, rd);
        ahb(32'h0610, 1'b0, 32'h0, rd);
        chk(rd, 32'h000a);
        for (int i = 0; i < 4; i++) begin
            run(mcid_pkg::SLFBK_PAT | 16'({i[0], codes[i]}));
            chk(32'({instr_denied, hs24_fbk_battery, hs24_auto_diag}),
                32'({1'b0, i[0], diag[i]}));
        end
    endtask

    task automatic t_adc;
        logic [31:0] rd;
        logic [3:0] exp;
        exp = 4'h0;
        run(mcid_pkg::STADC_PAT | 16'h5);
        chk(32'({instr_denied, conv_enable}), 32'h10);
        ahb(32'h0620, 1'b1, 32'h0011, rd);
        run(mcid_pkg::STADC_PAT | 16'h6);
        chk(32'({instr_denied, conv_enable}), 32'h10);
        ahb(32'h0624, 1'b1, 32'h0011, rd);
        for (int t = 0; t < 4; t++) begin
            run(mcid_pkg::STADC_PAT | 16'h4 | 16'(t));
            exp = exp | (4'h1 << t);
            chk(32'({instr_denied, conv_enable}), 32'(exp));
        end
        run(mcid_pkg::STADC_PAT | 16'h2);
        chk(32'(conv_enable), 32'hb);
        // Unmapped place: write dropped, read gives zero
        ahb(32'h0700, 1'b1, 32'hffff, rd);
        ahb(32'h0700, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        chk(32'({hreadyout, hresp}), 32'h2);
        // Status is read-only: the write is dropped
        ahb(32'h0628, 1'b1, 32'h0, rd);
        ahb(32'h0628, 1'b0, 32'h0, rd);
        chk(rd, 32'hb6fc);
    endtask

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Whole run is about a hundred cycles; this is far beyond it
    initial begin
        repeat (5000) @(posedge hclk);
        miscompares++;
        close_out;
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        alu_index_operand_reg = 16'h0015;
        spi_address_reg = 10'h2a5;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        t_reset;
        t_arith;
        t_base;
        t_spi;
        t_fbk;
        t_adc;
        // Reset again from a busy state, then repeat the reset checks
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        t_reset;
        close_out;
    end
endmodule

/* rtl/mcid_decoder.sv */
// Operation
// - Decode base-select, bit 0 picks source
// - Base from base register or index operand
// - Reset selects dedicated base register
// - Decode feedback-select, reference and diagnosis operands
// - HS2/4 reference boost or battery, boost reset
// - Diagnosis keep, ignore, disable or enable
// - Feedback change needs drive rights
// - Decode SPI address-select, bit 0 picks source
// - SPI address from register or index operand
// - Reset selects dedicated SPI address register
// - Load six-bit immediate into base register
// - Decode ADC-mode, enable and target operands
// - Enable 1 converts, 0 compares, reset 0
// - Target operand picks core and channel
// - ADC change needs current-block access rights
// - Decode arithmetic mode, copy two bits
// - Arithmetic mode encoding signed/unsigned, saturate
// - Overflow always flagged, clamp only saturating
// - Reset arithmetic mode unsigned without saturation
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
module mcid_decoder #(
    parameter logic CORE_ID = 1'b0,
    parameter logic CHAN_ID = 1'b0,
    parameter int SPI_AW = 10
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [15:0] alu_index_operand_reg,
    input wire logic [SPI_AW-1:0] spi_address_reg,
    output logic base_source_sel,
    output logic [5:0] index_base,
    output logic [5:0] data_ram_base,
    output logic spi_source_sel,
    output logic [SPI_AW-1:0] spi_addr,
    output logic hs24_fbk_battery,
    output logic hs24_auto_diag,
    output logic [3:0] conv_enable,
    output logic [1:0] arith_mode,
    output logic arith_signed,
    output logic arith_saturate,
    output logic overflow_flag_en,
    output logic instr_done,
    output logic instr_denied
);
    function automatic logic op_hit(input logic [15:0] ins,
                                    input logic [15:0] mask,
                                    input logic [15:0] pat);
        return (ins & mask) == pat;
    endfunction

    // Map a byte address to a local register slot
    function automatic logic [2:0] slot(input logic [31:0] a);
        logic [9:0] idx;
        idx = a[11:2];
        slot = mcid_pkg::LOC_NONE;
        if (a[31:12] == 20'h00000 && a[1:0] == 2'h0) begin
            if (idx >= mcid_pkg::IDX_DRV_A &&
                idx <= mcid_pkg::IDX_STATUS) begin
                slot = 3'(idx - mcid_pkg::IDX_DRV_A);
            end
        end
    endfunction

    // AHB-Lite slave: zero wait states, always OKAY
    logic hreadyout_q;
    logic wr_pend_q;
    logic [2:0] wr_slot_q;
    logic addr_phase;
    logic [2:0] a_slot;
    logic [2:0] rd_slot;
    logic [15:0] rd_word;
    logic [15:0] status_word;
    logic [16*mcid_pkg::NUM_ACC-1:0] acc_words;

    assign addr_phase = hsel && htrans[1] && hready;
    assign a_slot = slot(haddr);
    assign rd_slot = (addr_phase && !hwrite) ? a_slot : mcid_pkg::LOC_NONE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_slot_q <= mcid_pkg::LOC_NONE;
        end else if (hready) begin
            wr_pend_q <= addr_phase && hwrite &&
                         a_slot < mcid_pkg::LOC_STATUS;
            wr_slot_q <= a_slot;
        end
    end

    mcid_regmem #(.DW(16), .N(mcid_pkg::NUM_ACC)) u_acc (
        .clk(hclk),
        .rstn(hresetn),
        .we(wr_pend_q),
        .waddr(wr_slot_q),
        .wdata(hwdata[15:0]),
        .raddr(rd_slot),
        .ro_word(status_word),
        .rdata(rd_word),
        .words(acc_words)
    );

    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = {16'h0000, rd_word};

    // Instruction decode
    logic is_slab, is_slsa, is_slfbk, is_stab, is_stadc, is_stal;
    logic base_source_operand;
    logic spi_address_source_operand;
    logic [5:0] index_base_immediate;
    logic conv_enable_operand;
    logic [1:0] sense_block_target;
    logic [1:0] arith_mode_operand;
    logic fbk_ref_operand;
    logic [1:0] diag_operand;

    assign is_slab = instr_valid &&
        op_hit(instr, mcid_pkg::SLAB_MASK, mcid_pkg::SLAB_PAT);
    assign is_slsa = instr_valid &&
        op_hit(instr, mcid_pkg::SLSA_MASK, mcid_pkg::SLSA_PAT);
    assign is_slfbk = instr_valid &&
        op_hit(instr, mcid_pkg::SLFBK_MASK, mcid_pkg::SLFBK_PAT);
    assign is_stab = instr_valid &&
        op_hit(instr, mcid_pkg::STAB_MASK, mcid_pkg::STAB_PAT);
    assign is_stadc = instr_valid &&
        op_hit(instr, mcid_pkg::STADC_MASK, mcid_pkg::STADC_PAT);
    assign is_stal = instr_valid &&
        op_hit(instr, mcid_pkg::STAL_MASK, mcid_pkg::STAL_PAT);

    assign base_source_operand = instr[mcid_pkg::SEL_BIT];
    assign spi_address_source_operand = instr[mcid_pkg::SEL_BIT];
    assign index_base_immediate = instr[mcid_pkg::BASE_W-1:0];
    assign fbk_ref_operand = instr[mcid_pkg::REF_BIT];
    assign diag_operand = instr[1:0];
    assign conv_enable_operand = instr[mcid_pkg::CONV_BIT];
    assign sense_block_target = instr[1:0];
    assign arith_mode_operand = instr[1:0];

    // Access rights; core number within the device is {channel, core}
    logic [1:0] self_id;
    logic [1:0] tgt_blk;
    logic [15:0] drv_word;
    logic [15:0] cur_map;
    logic fb_ok;
    logic cur_ok;

    assign self_id = {CHAN_ID, CORE_ID};
    assign tgt_blk = {CHAN_ID ^ sense_block_target[mcid_pkg::TGT_CHAN_BIT],
        CORE_ID ^ sense_block_target[mcid_pkg::TGT_CORE_BIT]};
    assign drv_word = acc_words[16*self_id +: 16];
    assign fb_ok = drv_word[mcid_pkg::HS2_BIT] &&
                   drv_word[mcid_pkg::HS4_BIT];
    assign cur_map = {acc_words[16*mcid_pkg::LOC_CUR_2 +: 8],
                      acc_words[16*mcid_pkg::LOC_CUR_1 +: 8]};
    assign cur_ok = cur_map[{tgt_blk, self_id}];

    // Configuration state
    logic base_sel_q, base_sel_d;
    logic spi_sel_q, spi_sel_d;
    logic [5:0] base_q, base_d;
    logic [5:0] data_ram_base_q;
    logic [SPI_AW-1:0] spi_addr_q;
    logic fbk_q;
    logic diag_q;
    logic [3:0] conv_q;
    mcid_pkg::mcid_arith_e arith_q;
    logic arith_signed_q;
    logic arith_sat_q;
    logic done_q;
    logic denied_q;

    assign base_sel_d = is_slab ? base_source_operand : base_sel_q;
    assign spi_sel_d = is_slsa ? spi_address_source_operand : spi_sel_q;
    assign base_d = is_stab ? index_base_immediate : base_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_sel_q <= mcid_pkg::BASE_SEL_RST;
            spi_sel_q <= mcid_pkg::SPI_SEL_RST;
            base_q <= mcid_pkg::BASE_RST;
        end else begin
            base_sel_q <= base_sel_d;
            spi_sel_q <= spi_sel_d;
            base_q <= base_d;
        end
    end

    // Effective addresses look ahead so the next instruction sees them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_ram_base_q <= mcid_pkg::BASE_RST;
            spi_addr_q <= '0;
        end else begin
            data_ram_base_q <= base_sel_d ? alu_index_operand_reg[5:0]
                                          : base_d;
            spi_addr_q <= spi_sel_d ? alu_index_operand_reg[SPI_AW-1:0]
                                    : spi_address_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fbk_q <= mcid_pkg::FBK_RST;
            diag_q <= mcid_pkg::DIAG_RST;
        end else if (is_slfbk && fb_ok) begin
            fbk_q <= fbk_ref_operand;
            // Keep and the not-applicable code both leave diagnosis alone
            if (diag_operand == mcid_pkg::DIAG_OFF) begin
                diag_q <= 1'b0;
            end else if (diag_operand == mcid_pkg::DIAG_ON) begin
                diag_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_q <= mcid_pkg::CONV_RST;
        end else if (is_stadc && cur_ok) begin
            conv_q[tgt_blk] <= conv_enable_operand;
        end
    end

    // Signed for modes 00/01, clamp only for odd codes; held in flops
    // so the ALU mode inputs carry no decode logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arith_q <= mcid_pkg::ARITH_RST;
            arith_signed_q <= ~mcid_pkg::ARITH_RST[1];
            arith_sat_q <= mcid_pkg::ARITH_RST[0];
        end else if (is_stal) begin
            arith_q <= mcid_pkg::mcid_arith_e'(arith_mode_operand);
            arith_signed_q <= ~arith_mode_operand[1];
            arith_sat_q <= arith_mode_operand[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
            denied_q <= 1'b0;
        end else begin
            done_q <= is_slab || is_slsa || is_slfbk || is_stab ||
                      is_stadc || is_stal;
            denied_q <= (is_slfbk && !fb_ok) ||
                        (is_stadc && !cur_ok);
        end
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[mcid_pkg::ST_BASE_SEL] = base_sel_q;
        status_word[mcid_pkg::ST_SPI_SEL] = spi_sel_q;
        status_word[mcid_pkg::ST_BASE_LSB +: 6] = base_q;
        status_word[mcid_pkg::ST_ARITH_LSB +: 2] = arith_q;
        status_word[mcid_pkg::ST_FBK] = fbk_q;
        status_word[mcid_pkg::ST_DIAG] = diag_q;
        status_word[mcid_pkg::ST_CONV_LSB +: 4] = conv_q;
    end

    assign base_source_sel = base_sel_q;
    assign index_base = base_q;
    assign data_ram_base = data_ram_base_q;
    assign spi_source_sel = spi_sel_q;
    assign spi_addr = spi_addr_q;
    assign hs24_fbk_battery = fbk_q;
    assign hs24_auto_diag = diag_q;
    assign conv_enable = conv_q;
    assign arith_mode = arith_q;
    assign arith_signed = arith_signed_q;
    assign arith_saturate = arith_sat_q;
    // Overflow is reported in every mode
    assign overflow_flag_en = hreadyout_q;
    assign instr_done = done_q;
    assign instr_denied = denied_q;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_SLAB_SEL: assert property (
        is_slab |=> base_source_sel == $past(instr[0]))
        else $error("base source not taken from bit 0");

    AST_RAMBASE_REG: assert property (
        is_slab && !instr[0] |=> data_ram_base == $past(base_q))
        else $error("indexed base not from base register");

    AST_RAMBASE_IDX: assert property (
        is_slab && instr[0] |=>
            data_ram_base == $past(alu_index_operand_reg[5:0]))
        else $error("indexed base not from index operand");

    AST_STAB: assert property (
        is_stab |=> index_base == $past(instr[5:0]) ##1 $stable(index_base)
            || $past(is_stab))
        else $error("base immediate not loaded");

    AST_FBK_DENY: assert property (
        is_slfbk && !fb_ok |=> $stable(hs24_fbk_battery) &&
            $stable(hs24_auto_diag) && instr_denied)
        else $error("feedback changed without drive rights");

    AST_DIAG_KEEP: assert property (
        is_slfbk && fb_ok && instr[1:0] == 2'h0 |=> $stable(hs24_auto_diag))
        else $error("keep code changed diagnosis");

    AST_FBK_SET: assert property (
        is_slfbk && fb_ok && instr[1:0] == 2'h3 |=>
            hs24_auto_diag && hs24_fbk_battery == $past(instr[2]))
        else $error("feedback or diagnosis not applied");

    AST_SPI_IDX: assert property (
        is_slsa && instr[0] |=> spi_source_sel &&
            spi_addr == $past(alu_index_operand_reg[SPI_AW-1:0]))
        else $error("SPI address not from index operand");

    AST_ADC_DENY: assert property (
        is_stadc && !cur_ok |=> $stable(conv_enable) && instr_denied)
        else $error("ADC mode changed without access");

    AST_ADC_SET: assert property (
        is_stadc && cur_ok |=> conv_enable[$past(tgt_blk)] == $past(instr[2]))
        else $error("ADC mode not applied to target");

    AST_STAL: assert property (
        is_stal |=> arith_mode == $past(instr[1:0]))
        else $error("arithmetic mode not copied");

    AST_DONE: assert property (
        is_stal || is_slab || is_stadc |=> instr_done)
        else $error("instruction not completed in one cycle");
endmodule

/* rtl/mcid_pkg.sv */
package mcid_pkg;
    // Opcode match patterns, compared under the masks below
    localparam logic [15:0] SLAB_MASK = 16'hfffe;
    localparam logic [15:0] SLAB_PAT = 16'h360a;
    localparam logic [15:0] SLSA_MASK = 16'hfffe;
    localparam logic [15:0] SLSA_PAT = 16'h3608;
    localparam logic [15:0] SLFBK_MASK = 16'hfff8;
    localparam logic [15:0] SLFBK_PAT = 16'h3640;
    localparam logic [15:0] STAB_MASK = 16'hffc0;
    localparam logic [15:0] STAB_PAT = 16'h3400;
    localparam logic [15:0] STADC_MASK = 16'hfff8;
    localparam logic [15:0] STADC_PAT = 16'h3568;
    localparam logic [15:0] STAL_MASK = 16'hfffc;
    localparam logic [15:0] STAL_PAT = 16'h357c;

    // Operand field positions
    localparam int SEL_BIT = 0;
    localparam int REF_BIT = 2;
    localparam int CONV_BIT = 2;
    localparam int BASE_W = 6;

    // Diagnosis operand codes
    localparam logic [1:0] DIAG_KEEP = 2'h0;
    localparam logic [1:0] DIAG_NA = 2'h1;
    localparam logic [1:0] DIAG_OFF = 2'h2;
    localparam logic [1:0] DIAG_ON = 2'h3;

    // Target operand bits: bit 0 flips core, bit 1 flips channel
    localparam int TGT_CORE_BIT = 0;
    localparam int TGT_CHAN_BIT = 1;

    typedef enum logic [1:0] {
        signed_wrap_mode = 2'h0,
        signed_saturate_mode = 2'h1,
        unsigned_wrap_mode = 2'h2,
        unsigned_saturate_mode = 2'h3
    } mcid_arith_e;

    // Reset values
    localparam logic BASE_SEL_RST = 1'b0;
    localparam logic SPI_SEL_RST = 1'b0;
    localparam logic [5:0] BASE_RST = 6'h00;
    localparam logic FBK_RST = 1'b0;
    localparam logic DIAG_RST = 1'b0;
    localparam logic [3:0] CONV_RST = 4'h0;
    localparam mcid_arith_e ARITH_RST = unsigned_wrap_mode;
    localparam logic [15:0] ACC_RST = 16'h0000;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_DRV_A = 10'h184;
    localparam logic [9:0] IDX_DRV_B = 10'h185;
    localparam logic [9:0] IDX_DRV_C = 10'h186;
    localparam logic [9:0] IDX_DRV_D = 10'h187;
    localparam logic [9:0] IDX_CUR_1 = 10'h188;
    localparam logic [9:0] IDX_CUR_2 = 10'h189;
    localparam logic [9:0] IDX_STATUS = 10'h18a;
    localparam int NUM_ACC = 6;
    localparam logic [2:0] LOC_CUR_1 = 3'h4;
    localparam logic [2:0] LOC_CUR_2 = 3'h5;
    localparam logic [2:0] LOC_STATUS = 3'h6;
    localparam logic [2:0] LOC_NONE = 3'h7;

    // Drive-right bit positions in an output access word
    localparam int HS2_BIT = 1;
    localparam int HS4_BIT = 3;

    // Status word layout
    localparam int ST_BASE_SEL = 0;
    localparam int ST_SPI_SEL = 1;
    localparam int ST_BASE_LSB = 2;
    localparam int ST_ARITH_LSB = 8;
    localparam int ST_FBK = 10;
    localparam int ST_DIAG = 11;
    localparam int ST_CONV_LSB = 12;
endpackage

/* rtl/mcid_regmem.sv */
`timescale 1ns/1ns
module mcid_regmem #(
    parameter int DW = 16,
    parameter int N = 6
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [2:0] raddr,
    input wire logic [DW-1:0] ro_word,
    output logic [DW-1:0] rdata,
    output logic [N*DW-1:0] words
);
    logic [DW-1:0] mem_q [N];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N; i++) begin
                mem_q[i] <= mcid_pkg::ACC_RST;
            end
        end else if (we && (int'(waddr) < N)) begin
            mem_q[waddr] <= wdata;
        end
    end

    // Forward a write in flight so a read right behind it sees new data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else if (we && waddr == raddr && int'(raddr) < N) begin
            rdata_q <= wdata;
        end else if (int'(raddr) < N) begin
            rdata_q <= mem_q[raddr];
        end else if (int'(raddr) == N) begin
            rdata_q <= ro_word;
        end else begin
            rdata_q <= '0;
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            words[i*DW +: DW] = mem_q[i];
        end
    end

    assign rdata = rdata_q;
endmodule
